// [logic/cit_pkg.sv]
/*
  constants, types and opcode cost tables for the instruction timing core.
  assumes one clock, no wait states on program memory, and an execution
  datapath on the same clock that supplies accumulator and branch results.
*/
`default_nettype none

package cit_pkg;
  localparam int CIT_MAX_CYCLES = 8;
  localparam logic [15:0] CIT_PC_RESET = 16'h0000;
  localparam logic [15:0] CIT_DP_RESET = 16'h0000;
  localparam logic [7:0] CIT_OPC_SJMP = 8'h80;
  localparam logic [7:0] CIT_OPC_DP_LOAD = 8'h90;
  localparam logic [7:0] CIT_OPC_DP_INC = 8'hA3;
  localparam logic [7:0] CIT_OPC_CODE_PC = 8'h83;
  localparam logic [7:0] CIT_OPC_CODE_DP = 8'h93;
  localparam logic [7:0] CIT_OPC_LJMP = 8'h02;
  localparam logic [7:0] CIT_OPC_LCALL = 8'h12;
  localparam logic [7:0] CIT_OPC_RET = 8'h22;
  localparam logic [7:0] CIT_OPC_RETI = 8'h32;
  localparam logic [7:0] CIT_OPC_JMP_IND = 8'h73;
  localparam logic [7:0] CIT_OPC_DJNZ_DIR = 8'hD5;

  typedef enum logic [1:0] {
    CIT_ST_FETCH = 2'b01,
    CIT_ST_EXEC = 2'b10
  } cit_state_t;

  typedef enum logic [2:0] {
    CIT_JK_NONE = 3'h0,
    CIT_JK_REL = 3'h1,
    CIT_JK_ABS11 = 3'h2,
    CIT_JK_LONG = 3'h3,
    CIT_JK_EXT = 3'h4
  } cit_jump_t;

  // cost tables
  // one nibble per high opcode nibble, F at the top; columns by low nibble
  // 0..5, then 6-7 (indirect), then 8-F (bank register); cycles are taken-path
  localparam logic [63:0] CIT_CYC_TBL [8] = '{
    64'h3322_2233_3333_4441, 64'h3333_3333_3333_3333,
    64'h3322_2222_2222_5544, 64'h3311_1133_3333_1111,
    64'h1111_4428_2222_2211, 64'h2242_4123_3222_2222,
    64'h2222_5222_2222_2222, 64'h1131_4212_2111_1111
  };
  localparam logic [63:0] CIT_LEN_TBL [8] = '{
    64'h1122_2232_2222_3331, 64'h2222_2222_2222_2222,
    64'h1122_2222_2222_1133, 64'h1111_1111_1333_1111,
    64'h1111_3121_2222_2211, 64'h2232_3123_3222_2222,
    64'h1111_3212_2111_1111, 64'h1121_3212_2111_1111
  };

  function automatic logic [2:0] col_of(input logic [3:0] lo);
    if (lo[3]) begin
      col_of = 3'h7;
    end else if (lo[2:1] == 2'b11) begin
      col_of = 3'h6;
    end else begin
      col_of = lo[2:0];
    end
  endfunction
endpackage

`default_nettype wire

// [logic/cit_decode.sv]
/*
  opcode decoder: byte length, taken-path cycle count and operation class.
  purely combinational; the caller registers what it keeps.
*/
`default_nettype none

module cit_decode (
  input wire logic [7:0] opcode,
  output logic [1:0] n_bytes,
  output logic [3:0] n_cycles,
  output logic is_cond,
  output cit_pkg::cit_jump_t jump_kind,
  output logic flash_rd,
  output logic flash_wr,
  output logic code_rd,
  output logic code_rel_pc,
  output logic dp_load,
  output logic dp_inc
);
  logic [2:0] col;
  logic [3:0] hi;
  logic [3:0] lo;
  logic flash_form;

  always_comb begin
    hi = opcode[7:4];
    lo = opcode[3:0];
    col = cit_pkg::col_of(lo);
    n_cycles = cit_pkg::CIT_CYC_TBL[col][{hi, 2'b00} +: 4];
    n_bytes = cit_pkg::CIT_LEN_TBL[col][{hi, 2'b00} +: 2];
    // jc/jnc/jz/jnz/jb/jnb/jbc, all cjne forms, djnz
    is_cond = ((lo == 4'h0) && (hi != 4'h0) && !hi[3])
      || ((hi == 4'hB) && (col >= 3'h4))
      || ((hi == 4'hD) && (lo[3] || (opcode == cit_pkg::CIT_OPC_DJNZ_DIR)));
    if (is_cond || (opcode == cit_pkg::CIT_OPC_SJMP)) begin
      jump_kind = cit_pkg::CIT_JK_REL;
    end else if (lo == 4'h1) begin
      jump_kind = cit_pkg::CIT_JK_ABS11;
    end else if ((opcode == cit_pkg::CIT_OPC_LJMP) || (opcode == cit_pkg::CIT_OPC_LCALL)) begin
      jump_kind = cit_pkg::CIT_JK_LONG;
    end else if ((opcode == cit_pkg::CIT_OPC_RET) || (opcode == cit_pkg::CIT_OPC_RETI)
        || (opcode == cit_pkg::CIT_OPC_JMP_IND)) begin
      jump_kind = cit_pkg::CIT_JK_EXT;
    end else begin
      jump_kind = cit_pkg::CIT_JK_NONE;
    end
    flash_form = (lo == 4'h0) || (lo[3:1] == 3'b001);
    flash_rd = (hi == 4'hE) && flash_form;
    flash_wr = (hi == 4'hF) && flash_form;
    code_rd = (opcode == cit_pkg::CIT_OPC_CODE_PC) || (opcode == cit_pkg::CIT_OPC_CODE_DP);
    code_rel_pc = (opcode == cit_pkg::CIT_OPC_CODE_PC);
    dp_load = (opcode == cit_pkg::CIT_OPC_DP_LOAD);
    dp_inc = (opcode == cit_pkg::CIT_OPC_DP_INC);
  end
endmodule

`default_nettype wire

// [logic/cit_core_timer.sv]
/*
  instruction sequencer: fetches opcode and operand bytes from on-chip
  program memory, times each instruction, steers program flow, and routes
  flash space moves and code byte reads onto the same on-chip port.
  assumes program memory reads asynchronously from pmem_addr_r with no wait
  states, and that acc, ri_value, bank_sel, branch_taken and ext_target come
  from datapath logic on ref_clk.
*/
`default_nettype none

module cit_core_timer (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] pmem_rdata,
  input wire logic [7:0] acc,
  input wire logic [7:0] ri_value,
  input wire logic [1:0] bank_sel,
  input wire logic branch_taken,
  input wire logic [15:0] ext_target,
  output logic [15:0] pmem_addr_r,
  output logic pmem_wr_r,
  output logic [7:0] pmem_wdata_r,
  output logic instr_start_r,
  output logic [3:0] instr_cycles_r,
  output logic [7:0] opcode_r,
  output logic [7:0] operand1_r,
  output logic [7:0] operand2_r,
  output logic [15:0] data_pointer_r,
  output logic acc_load_r,
  output logic [7:0] acc_data_r,
  output logic [7:0] bank_reg_addr_r,
  output logic [7:0] ptr_reg_addr_r
);
  cit_pkg::cit_state_t state_r;
  cit_pkg::cit_jump_t jump_kind;
  logic [2:0] cyc_r;
  logic [15:0] pc_r;
  logic taken_r;
  logic [7:0] dec_opc;
  logic [1:0] n_bytes;
  logic [3:0] n_cycles;
  logic is_cond;
  logic flash_rd;
  logic flash_wr;
  logic code_rd;
  logic code_rel_pc;
  logic dp_load;
  logic dp_inc;
  logic is_fetch;
  logic fetching;
  logic last_byte;
  logic eff_taken;
  logic [3:0] n_eff;
  logic final_cyc;
  logic [7:0] byte1_w;
  logic [7:0] byte2_w;
  logic [7:0] rel_w;
  logic [15:0] seq_w;
  logic [15:0] target_w;
  logic take_w;
  logic [15:0] next_pc;
  logic data_nxt;
  logic [15:0] data_addr;
  logic [15:0] addr_nxt;

  assign is_fetch = (state_r == cit_pkg::CIT_ST_FETCH);
  // the opcode is only on the bus in the fetch cycle
  assign dec_opc = is_fetch ? pmem_rdata : opcode_r;

  cit_decode u_decode (
    .opcode(dec_opc),
    .n_bytes(n_bytes),
    .n_cycles(n_cycles),
    .is_cond(is_cond),
    .jump_kind(jump_kind),
    .flash_rd(flash_rd),
    .flash_wr(flash_wr),
    .code_rd(code_rd),
    .code_rel_pc(code_rel_pc),
    .dp_load(dp_load),
    .dp_inc(dp_inc)
  );

  always_comb begin
    fetching = (cyc_r < {1'b0, n_bytes});
    last_byte = (cyc_r == ({1'b0, n_bytes} - 3'd1));
    // condition is known once the last byte (the offset) arrives
    eff_taken = last_byte ? branch_taken : taken_r;
    n_eff = n_cycles - {3'b000, (is_cond && !eff_taken)};
    final_cyc = ({1'b0, cyc_r} == (n_eff - 4'd1));
    byte1_w = (cyc_r == 3'd1) ? pmem_rdata : operand1_r;
    byte2_w = (cyc_r == 3'd2) ? pmem_rdata : operand2_r;
    rel_w = (n_bytes == 2'd2) ? byte1_w : byte2_w;
    seq_w = fetching ? (pc_r + 16'h0001) : pc_r;
    unique case (jump_kind)
      cit_pkg::CIT_JK_REL: target_w = seq_w + {{8{rel_w[7]}}, rel_w};
      cit_pkg::CIT_JK_ABS11: target_w = {seq_w[15:11], dec_opc[7:5], byte1_w};
      cit_pkg::CIT_JK_LONG: target_w = {byte1_w, byte2_w};
      cit_pkg::CIT_JK_EXT: target_w = ext_target;
      default: target_w = seq_w;
    endcase
    take_w = is_cond ? eff_taken : (jump_kind != cit_pkg::CIT_JK_NONE);
    next_pc = take_w ? target_w : seq_w;
    data_nxt = (flash_rd || flash_wr || code_rd) && (cyc_r == 3'd0);
    // code byte at data pointer, or next pc for the pc form, plus accumulator
    if (code_rd) begin
      data_addr = (code_rel_pc ? seq_w : data_pointer_r) + {8'h00, acc};
    // flash space move stays in program space
    end else if (dec_opc[1]) begin
      data_addr = {8'h00, ri_value};
    end else begin
      data_addr = data_pointer_r;
    end
    if (final_cyc) begin
      addr_nxt = next_pc;
    end else if ((cyc_r + 3'd1) < {1'b0, n_bytes}) begin
      addr_nxt = pc_r + 16'h0001;
    end else if (data_nxt) begin
      addr_nxt = data_addr;
    end else begin
      addr_nxt = next_pc;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= cit_pkg::CIT_ST_FETCH;
      cyc_r <= 3'd0;
    end else if (final_cyc) begin
      state_r <= cit_pkg::CIT_ST_FETCH;
      cyc_r <= 3'd0;
    end else begin
      state_r <= cit_pkg::CIT_ST_EXEC;
      cyc_r <= cyc_r + 3'd1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_r <= cit_pkg::CIT_PC_RESET;
      pmem_addr_r <= cit_pkg::CIT_PC_RESET;
    end else begin
      pmem_addr_r <= addr_nxt;
      if (final_cyc) begin
        pc_r <= next_pc;
      end else if (fetching) begin
        pc_r <= pc_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_start_r <= 1'b1;
      instr_cycles_r <= 4'd0;
      taken_r <= 1'b0;
    end else begin
      instr_start_r <= final_cyc;
      if (final_cyc) begin
        instr_cycles_r <= n_eff;
      end
      if (last_byte) begin
        taken_r <= branch_taken;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      opcode_r <= 8'h00;
      operand1_r <= 8'h00;
      operand2_r <= 8'h00;
    end else begin
      if (is_fetch) begin
        opcode_r <= pmem_rdata;
      end
      if (fetching && (cyc_r == 3'd1)) begin
        operand1_r <= pmem_rdata;
      end
      if (fetching && (cyc_r == 3'd2)) begin
        operand2_r <= pmem_rdata;
      end
    end
  end

  // pointer is register 0 or 1
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_reg_addr_r <= 8'h00;
      ptr_reg_addr_r <= 8'h00;
    end else if (is_fetch) begin
      bank_reg_addr_r <= {3'b000, bank_sel, pmem_rdata[2:0]};
      ptr_reg_addr_r <= {3'b000, bank_sel, 2'b00, pmem_rdata[0]};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_pointer_r <= cit_pkg::CIT_DP_RESET;
    end else if (final_cyc && dp_load) begin
      data_pointer_r <= {byte1_w, byte2_w};
    end else if (final_cyc && dp_inc) begin
      data_pointer_r <= data_pointer_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pmem_wr_r <= 1'b0;
      pmem_wdata_r <= 8'h00;
      acc_load_r <= 1'b0;
      acc_data_r <= 8'h00;
    end else begin
      pmem_wr_r <= data_nxt && flash_wr;
      if (data_nxt && flash_wr) begin
        pmem_wdata_r <= acc;
      end
      acc_load_r <= (cyc_r == 3'd1) && (flash_rd || code_rd);
      if ((cyc_r == 3'd1) && (flash_rd || code_rd)) begin
        acc_data_r <= pmem_rdata;
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_cycle_bound: assert property (
    is_fetch |-> (n_cycles >= 4'd1) && (n_cycles <= 4'(cit_pkg::CIT_MAX_CYCLES)))
    else $error("instruction cost outside one to eight cycles");
  a_notaken_save: assert property (
    (final_cyc && is_cond) |-> ({1'b0, cyc_r} + 4'd1 + {3'b000, !eff_taken}) == n_cycles)
    else $error("branch length does not follow its outcome");
  a_one_cycle: assert property (
    (is_fetch && n_cycles == 4'd1 && n_bytes == 2'd1) |=> instr_start_r)
    else $error("one byte one cycle instruction did not end");
  a_add_cost: assert property (
    (is_fetch && pmem_rdata[7:4] inside {4'h2, 4'h3, 4'h9} && pmem_rdata[3:0] >= 4'h4)
    |-> (pmem_rdata[3] ? (n_bytes == 2'd1 && n_cycles == 4'd1)
      : pmem_rdata[2:1] == 2'b11 ? (n_bytes == 2'd1 && n_cycles == 4'd2)
      : (n_bytes == 2'd2 && n_cycles == 4'd2)))
    else $error("arithmetic cost wrong");
  a_logic_cost: assert property (
    (is_fetch && pmem_rdata[7:4] inside {4'h4, 4'h5, 4'h6} && pmem_rdata[3:0] >= 4'h4)
    |-> (pmem_rdata[3] ? n_cycles == 4'd1 : n_cycles == 4'd2)
      && (n_bytes == ((pmem_rdata[3] || pmem_rdata[2:1] == 2'b11) ? 2'd1 : 2'd2)))
    else $error("logic into accumulator cost wrong");
  a_logic_direct: assert property (
    (is_fetch && pmem_rdata inside {8'h42, 8'h52, 8'h62, 8'h43, 8'h53, 8'h63})
    |-> (pmem_rdata[0] ? (n_bytes == 2'd3 && n_cycles == 4'd3)
      : (n_bytes == 2'd2 && n_cycles == 4'd2)))
    else $error("logic into direct byte cost wrong");
  a_acc_only: assert property (
    (is_fetch && pmem_rdata inside {8'hE4, 8'hF4, 8'h03, 8'h13, 8'h23, 8'h33, 8'hC4, 8'hD4})
    |=> instr_start_r && pmem_addr_r == $past(pmem_addr_r) + 16'h0001)
    else $error("accumulator operation not one byte one cycle");
  a_move_direct: assert property (
    (is_fetch && pmem_rdata inside {8'h85, 8'h75}) |=> !instr_start_r [*2] ##1 instr_start_r)
    else $error("direct destination move not three cycles");
  a_move_indirect: assert property (
    (is_fetch && pmem_rdata inside {8'hF6, 8'hF7, 8'hA6, 8'hA7, 8'h76, 8'h77})
    |-> n_cycles == 4'd2 && n_bytes == (pmem_rdata[7:4] == 4'hF ? 2'd1 : 2'd2))
    else $error("indirect destination move cost wrong");
  a_move_bank: assert property (
    (is_fetch && pmem_rdata[3] && pmem_rdata[7:4] inside {4'hE, 4'hF, 4'hA, 4'h7})
    |-> pmem_rdata[7:5] == 3'b111 ? (n_bytes == 2'd1 && n_cycles == 4'd1)
      : (n_bytes == 2'd2 && n_cycles == 4'd2))
    else $error("bank register move cost wrong");
  a_pointer_load: assert property (
    (is_fetch && pmem_rdata == cit_pkg::CIT_OPC_DP_LOAD)
    |-> ##3 instr_start_r && data_pointer_r == {$past(pmem_rdata, 2), $past(pmem_rdata)})
    else $error("data pointer load wrong");
  a_code_read: assert property (
    (is_fetch && pmem_rdata == cit_pkg::CIT_OPC_CODE_DP)
    |=> !instr_start_r ##1 (acc_load_r && !instr_start_r) ##1 instr_start_r)
    else $error("code byte read timing wrong");
  a_flash_redirect: assert property (
    (is_fetch && pmem_rdata == 8'hF0) |=> pmem_wr_r && pmem_addr_r == data_pointer_r)
    else $error("flash space write not on program port");
  a_bank_select: assert property (
    (is_fetch && pmem_rdata[3])
    |=> bank_reg_addr_r[7:5] == 3'b000 && bank_reg_addr_r[2:0] == $past(pmem_rdata[2:0]))
    else $error("bank register select wrong");
  a_ptr_select: assert property (
    (is_fetch && pmem_rdata[3:1] == 3'b011) |=> ptr_reg_addr_r[2:1] == 2'b00
      && ptr_reg_addr_r[4:3] == $past(bank_sel))
    else $error("indirect pointer register wrong");

  c_notaken: cover property (final_cyc && is_cond && !eff_taken);
  c_taken: cover property (final_cyc && is_cond && eff_taken);
  c_flash_wr: cover property (pmem_wr_r);
  c_code_rd: cover property (acc_load_r);
endmodule

`default_nettype wire

// [dv/cit_pmem_model.sv]
/*
  behavioural on-chip program memory facing the instruction timing core.
  assumes one clock; reads are combinational from the address register,
  writes land on the rising edge; the bench preloads mem hierarchically.
*/
`default_nettype none

module cit_pmem_model (
  input wire logic ref_clk,
  input wire logic [15:0] pmem_addr_r,
  input wire logic pmem_wr_r,
  input wire logic [7:0] pmem_wdata_r,
  output logic [7:0] pmem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:8191];

  // on-chip, no wait states
  // only 8K populated, upper space mirrors rather than floating
  assign pmem_rdata = mem[pmem_addr_r[12:0]];

  // flash space write
  // plain always: the bench also preloads this array
  always @(posedge ref_clk) begin
    if (pmem_wr_r === 1'b1) begin
      mem[pmem_addr_r[12:0]] <= pmem_wdata_r;
    end
  end
endmodule

`default_nettype wire

// [dv/test_cit_core_timer.sv]
/*
  self-checking bench for the instruction timing core: measures the span
  between opcode fetches per instruction class and the side effects.
  assumes the program memory model above and no wait states.
*/
`default_nettype none

module test_cit_core_timer;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk;
  logic arst_n;
  logic [7:0] pmem_rdata;
  logic [7:0] acc;
  logic [7:0] ri_value;
  logic [1:0] bank_sel;
  logic branch_taken;
  logic [15:0] ext_target;
  logic [15:0] pmem_addr_r;
  logic pmem_wr_r;
  logic [7:0] pmem_wdata_r;
  logic instr_start_r;
  logic [3:0] instr_cycles_r;
  logic [15:0] data_pointer_r;
  logic acc_load_r;
  logic [7:0] acc_data_r;
  logic [7:0] bank_reg_addr_r;
  logic [7:0] ptr_reg_addr_r;
  logic [7:0] opcode_r;
  logic [7:0] operand1_r;
  logic [7:0] operand2_r;
  int error_cnt = 0;
  int n_checks = 0;
  logic [7:0] prog [$];
  int len_q [$];
  int exp_cyc [$];
  logic wr_seen;
  logic [15:0] wr_addr;
  logic [7:0] wr_data;
  logic ld_seen;
  logic [7:0] ld_data;
  logic [15:0] c1_addr;

  cit_core_timer cit_core_timer_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .pmem_rdata(pmem_rdata), .acc(acc), .ri_value(ri_value), .bank_sel(bank_sel),
    .branch_taken(branch_taken), .ext_target(ext_target), .pmem_addr_r(pmem_addr_r),
    .pmem_wr_r(pmem_wr_r), .pmem_wdata_r(pmem_wdata_r), .instr_start_r(instr_start_r),
    .instr_cycles_r(instr_cycles_r), .opcode_r(opcode_r), .operand1_r(operand1_r),
    .operand2_r(operand2_r),
    .data_pointer_r(data_pointer_r), .acc_load_r(acc_load_r), .acc_data_r(acc_data_r),
    .bank_reg_addr_r(bank_reg_addr_r), .ptr_reg_addr_r(ptr_reg_addr_r));

  cit_pmem_model cit_pmem_model_inst (.ref_clk(ref_clk), .pmem_addr_r(pmem_addr_r),
    .pmem_wr_r(pmem_wr_r), .pmem_wdata_r(pmem_wdata_r), .pmem_rdata(pmem_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // reset doubles as the program load window
  task automatic start_prog();
    @(negedge ref_clk);
    arst_n = 1'b0;
    for (int i = 0; i < 8192; i++) begin
      cit_pmem_model_inst.mem[i] = 8'h00;
    end
    foreach (prog[i]) begin
      cit_pmem_model_inst.mem[i] = prog[i];
    end
    prog = {};
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
  endtask

  // called in a fetch cycle; returns in the next fetch cycle
  task automatic step(input int exp, input string what);
    int cnt;
    cnt = 0;
    wr_seen = 1'b0;
    ld_seen = 1'b0;
    do begin
      @(negedge ref_clk);
      cnt++;
      if (cnt == 1) begin
        c1_addr = pmem_addr_r;
      end
      if (pmem_wr_r === 1'b1) begin
        wr_seen = 1'b1;
        wr_addr = pmem_addr_r;
        wr_data = pmem_wdata_r;
      end
      if (acc_load_r === 1'b1) begin
        ld_seen = 1'b1;
        ld_data = acc_data_r;
      end
    end while (instr_start_r !== 1'b1 && cnt < 12);
    check(cnt == exp, {what, " fetch to fetch span"});
    check(instr_cycles_r === 4'(exp), {what, " reported cycles"});
  endtask

  task automatic add(input logic [7:0] op, input int len, input int cyc);
    prog.push_back(op);
    repeat (len - 1) prog.push_back(8'h30);
    len_q.push_back(len);
    exp_cyc.push_back(cyc);
  endtask

  task automatic run_exp(input string what);
    logic [15:0] pc;
    pc = 16'h0000;
    start_prog();
    foreach (exp_cyc[i]) begin
      step(exp_cyc[i], what);
      pc = pc + 16'(len_q[i]);
      check(pmem_addr_r === pc, {what, " next fetch address"});
    end
    exp_cyc = {};
    len_q = {};
  endtask

  task automatic t_arith();
    logic [7:0] b [3] = '{8'h20, 8'h30, 8'h90};
    foreach (b[i]) begin
      add(b[i] + 8'h08, 1, 1);
      add(b[i] + 8'h05, 2, 2);
      add(b[i] + 8'h06, 1, 2);
      add(b[i] + 8'h04, 2, 2);
    end
    run_exp("arith");
  endtask

  task automatic t_logic();
    logic [7:0] b [3] = '{8'h50, 8'h40, 8'h60};
    foreach (b[i]) begin
      add(b[i] + 8'h08, 1, 1);
      add(b[i] + 8'h05, 2, 2);
      add(b[i] + 8'h06, 1, 2);
      add(b[i] + 8'h04, 2, 2);
      add(b[i] + 8'h02, 2, 2);
      add(b[i] + 8'h03, 3, 3);
    end
    run_exp("logic");
  endtask

  task automatic t_single();
    logic [7:0] ops [8] = '{8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hD4};
    foreach (ops[i]) begin
      add(ops[i], 1, 1);
    end
    add(8'h84, 1, 8);
    add(8'hA4, 1, 4);
    run_exp("single byte");
  endtask

  task automatic t_moves();
    add(8'h85, 3, 3);
    add(8'h75, 3, 3);
    add(8'hF6, 1, 2);
    add(8'hA6, 2, 2);
    add(8'h76, 2, 2);
    add(8'hE8, 1, 1);
    add(8'hF8, 1, 1);
    add(8'hA8, 2, 2);
    add(8'h78, 2, 2);
    run_exp("moves");
  endtask

  task automatic t_bank();
    for (int b = 0; b < 4; b++) begin
      bank_sel = 2'(b);
      prog = {8'hED, 8'h27};
      start_prog();
      step(1, "bank move");
      check(bank_reg_addr_r === {3'b000, 2'(b), 3'b101}, "bank register address");
      step(2, "indirect add");
      check(ptr_reg_addr_r === {3'b000, 2'(b), 3'b001}, "pointer register address");
    end
  endtask

  task automatic t_code_read();
    acc = 8'h05;
    prog = {8'h90, 8'h01, 8'h00, 8'h93, 8'h90, 8'h12, 8'h34};
    start_prog();
    cit_pmem_model_inst.mem[16'h0105] = 8'h5A;
    step(3, "pointer load");
    check(data_pointer_r === 16'h0100, "pointer value");
    step(3, "code read");
    check(c1_addr === 16'h0105, "code read address");
    check(ld_seen === 1'b1 && ld_data === 8'h5A && wr_seen === 1'b0, "code read data");
    check(pmem_addr_r === 16'h0004, "fetch after code read");
    step(3, "pointer reload");
    check(data_pointer_r === 16'h1234, "pointer reload value");
    check(opcode_r === 8'h90 && operand1_r === 8'h12 && operand2_r === 8'h34, "bytes");
  endtask

  task automatic t_flash();
    acc = 8'hC3;
    prog = {8'h90, 8'h01, 8'h80, 8'hF0, 8'hE0, 8'hF2};
    start_prog();
    step(3, "pointer load");
    step(3, "flash write");
    check(wr_seen === 1'b1 && wr_addr === 16'h0180 && wr_data === 8'hC3, "write");
    check(cit_pmem_model_inst.mem[16'h0180] === 8'hC3, "flash byte stored");
    acc = 8'h00;
    step(3, "flash read");
    check(ld_seen === 1'b1 && ld_data === 8'hC3 && wr_seen === 1'b0, "read back");
    acc = 8'h3C;
    ri_value = 8'h40;
    step(3, "register pointer write");
    check(wr_seen === 1'b1 && wr_addr === 16'h0040 && wr_data === 8'h3C, "reg write");
    ri_value = 8'h00;
  endtask

  task automatic t_branch();
    for (int t = 0; t < 2; t++) begin
      branch_taken = t[0];
      prog = {8'h40, 8'h02};
      start_prog();
      step(2 + t, "branch");
      check(pmem_addr_r === (t[0] ? 16'h0004 : 16'h0002), "branch target");
    end
    branch_taken = 1'b0;
  endtask

  initial begin
    arst_n = 1'b0;
    acc = 8'h00;
    ri_value = 8'h00;
    bank_sel = 2'b00;
    branch_taken = 1'b0;
    ext_target = 16'h0000;
    t_arith();
    t_logic();
    t_single();
    t_moves();
    t_bank();
    t_code_read();
    t_flash();
    t_branch();
    end_sim();
  end

  // whole run is under two hundred cycles against a 10000 cycle limit; this is ample margin
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule

`default_nettype wire
